// ---- hw/rtcc_core.sv ----
// Clock control and time value of the precision-time real time clock.
// Assumes register strobes come from logic on i_clk, one access a cycle.
`timescale 1ns/1ps

module rtcc_core (
    input  wire logic                i_clk,
    input  wire logic                i_reset_n,
    input  wire logic                i_reg_wr,
    input  wire logic                i_reg_rd,
    input  wire logic [15:0]         i_reg_addr,
    input  wire logic [15:0]         i_reg_wdata,
    output logic      [15:0]         o_reg_rdata,
    output logic                     o_reg_rvalid,
    output rtcc_pkg::rtcc_time_s     o_rtc_time,
    output logic                     o_rtc_running,
    output logic                     o_timer_follow,
    output logic                     o_timer_sign
);
    import rtcc_pkg::*;

    rtcc_ctrl_s  ctrl_q,   ctrl_d;
    rtcc_time_s  shadow_q, shadow_d;
    rtcc_rate_s  rate_q,   rate_d;
    rtcc_time_s  live_q,   live_d;
    logic [FRAC_W-1:0] frac_q, frac_d;
    logic [1:0]  tick_cnt_q, tick_cnt_d;
    logic [15:0] rdata_q,  rdata_d;
    logic        rvalid_q, rvalid_d;
    logic        follow_q, follow_d;
    logic        sign_q,   sign_d;
    logic        tick;
    logic        wr_ctrl;

    // Add or subtract a nanosecond amount below one second, wrapping seconds
    function automatic rtcc_time_s time_shift(input rtcc_time_s t,
                                              input logic [31:0] d,
                                              input logic        neg);
        logic [32:0] s;
        rtcc_time_s  r;
        r = t;
        s = 33'h000000000;
        if (!neg) begin
            s = {1'b0, t.ns} + {1'b0, d};
            if (s >= NS_PER_SEC) begin
                r.ns  = 32'(s - NS_PER_SEC);
                r.sec = t.sec + 32'h00000001;
            end else begin
                r.ns = s[31:0];
            end
        end else if (t.ns >= d) begin
            r.ns = t.ns - d;
        end else begin
            s     = {1'b0, t.ns} + NS_PER_SEC - {1'b0, d};
            r.ns  = s[31:0];
            r.sec = t.sec - 32'h00000001;
        end
        return r;
    endfunction : time_shift

    // Tick counter runs free; a load does not realign the 40 ns grid
    assign tick    = (tick_cnt_q == TICK_LAST);
    assign wr_ctrl = i_reg_wr && (i_reg_addr == OFS_CTRL);

    // Register file: control, shadow time, rate, and read port
    always_comb begin
        ctrl_d   = ctrl_q;
        shadow_d = shadow_q;
        rate_d   = rate_q;
        rdata_d  = rdata_q;
        rvalid_d = i_reg_rd;
        // Commands clear after the cycle that acted on them
        ctrl_d.step      = 1'b0;
        ctrl_d.snap      = 1'b0;
        ctrl_d.load      = 1'b0;
        ctrl_d.clk_reset = 1'b0;
        // Snapshot first, so a bus write in the same cycle wins
        if (ctrl_q.snap) begin
            shadow_d = live_q;
        end
        if (i_reg_wr) begin
            case (i_reg_addr)
                OFS_CTRL: begin
                    // Bits 14:7 are not stored at all
                    ctrl_d.freq_dis  = i_reg_wdata[BIT_FREQ_DIS];
                    ctrl_d.step      = i_reg_wdata[BIT_STEP];
                    ctrl_d.step_dir  = i_reg_wdata[BIT_STEP_DIR];
                    ctrl_d.snap      = i_reg_wdata[BIT_SNAP];
                    ctrl_d.load      = i_reg_wdata[BIT_LOAD];
                    ctrl_d.cont_adj  = i_reg_wdata[BIT_CONT_ADJ];
                    ctrl_d.enable    = i_reg_wdata[BIT_ENABLE];
                    ctrl_d.clk_reset = i_reg_wdata[BIT_CLK_RESET];
                end
                // Invalid phase codes are stored as written, no checking
                OFS_PHASE:      shadow_d.phase = i_reg_wdata[PHASE_W-1:0];
                OFS_NS_UPPER:   shadow_d.ns[31:16]  = i_reg_wdata;
                OFS_NS_LOWER:   shadow_d.ns[15:0]   = i_reg_wdata;
                OFS_SEC_UPPER:  shadow_d.sec[31:16] = i_reg_wdata;
                OFS_SEC_LOWER:  shadow_d.sec[15:0]  = i_reg_wdata;
                OFS_RATE_UPPER: begin
                    rate_d.rate_sign_select = i_reg_wdata[BIT_RATE_SIGN];
                    rate_d.fractional_rate_value[FRAC_W-1:16] =
                        i_reg_wdata[RATE_HI_W-1:0];
                end
                OFS_RATE_LOWER: rate_d.fractional_rate_value[15:0] = i_reg_wdata;
                default: ;
            endcase
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                OFS_CTRL:       rdata_d = {ctrl_q.freq_dis, 8'h00, ctrl_q.step,
                                           ctrl_q.step_dir, ctrl_q.snap, ctrl_q.load,
                                           ctrl_q.cont_adj, ctrl_q.enable,
                                           ctrl_q.clk_reset};
                OFS_PHASE:      rdata_d = {13'h0000, shadow_q.phase};
                OFS_NS_UPPER:   rdata_d = shadow_q.ns[31:16];
                OFS_NS_LOWER:   rdata_d = shadow_q.ns[15:0];
                OFS_SEC_UPPER:  rdata_d = shadow_q.sec[31:16];
                OFS_SEC_LOWER:  rdata_d = shadow_q.sec[15:0];
                OFS_RATE_UPPER: rdata_d = {rate_q.rate_sign_select, 1'b0,
                                           rate_q.fractional_rate_value[FRAC_W-1:16]};
                OFS_RATE_LOWER: rdata_d = rate_q.fractional_rate_value[15:0];
                default:        rdata_d = RST_WORD;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ctrl_q   <= '0;
            shadow_q <= '0;
            rate_q   <= '0;
            rdata_q  <= RST_WORD;
            rvalid_q <= 1'b0;
        end else begin
            ctrl_q   <= ctrl_d;
            shadow_q <= shadow_d;
            rate_q   <= rate_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Time core: reset beats load, load beats step, step beats ticking
    always_comb begin
        logic [FRAC_W:0] acc;
        acc        = {1'b0, frac_q};
        live_d     = live_q;
        frac_d     = frac_q;
        tick_cnt_d = tick_cnt_q + 2'h1;
        follow_d   = ctrl_q.enable && ctrl_q.cont_adj && !ctrl_q.freq_dis;
        sign_d     = rate_q.rate_sign_select;
        // Load keeps the fraction, so the rate phase survives a time load
        if (ctrl_q.clk_reset) begin
            live_d = '0;
            frac_d = '0;
        end else if (ctrl_q.load) begin
            live_d = shadow_q;
        end else if (ctrl_q.step) begin
            live_d = time_shift(live_q, shadow_q.ns, !ctrl_q.step_dir);
        end else if (ctrl_q.enable && tick) begin
            if (ctrl_q.cont_adj) begin
                // Fraction overflow or borrow moves the clock by one ns
                if (rate_q.rate_sign_select) begin
                    acc = {1'b0, frac_q} + {1'b0, rate_q.fractional_rate_value};
                    live_d = time_shift(live_q, NS_PER_TICK + {31'h0, acc[FRAC_W]},
                                        1'b0);
                end else begin
                    acc = {1'b0, frac_q} - {1'b0, rate_q.fractional_rate_value};
                    live_d = time_shift(live_q, NS_PER_TICK - {31'h0, acc[FRAC_W]},
                                        1'b0);
                end
                frac_d = acc[FRAC_W-1:0];
            end else begin
                live_d = time_shift(live_q, NS_PER_TICK, 1'b0);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            live_q     <= '0;
            frac_q     <= '0;
            tick_cnt_q <= 2'h0;
            follow_q   <= 1'b0;
            sign_q     <= 1'b0;
        end else begin
            live_q     <= live_d;
            frac_q     <= frac_d;
            tick_cnt_q <= tick_cnt_d;
            follow_q   <= follow_d;
            sign_q     <= sign_d;
        end
    end

    // Outputs come straight from flops
    assign o_reg_rdata    = rdata_q;
    assign o_reg_rvalid   = rvalid_q;
    assign o_rtc_time     = live_q;
    assign o_rtc_running  = ctrl_q.enable;
    assign o_timer_follow = follow_q;
    assign o_timer_sign   = sign_q;

    // Self-clearing step command lasts one cycle
    chk_step_self_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (ctrl_q.step && !wr_ctrl) |=> !ctrl_q.step)
        else $error("step command did not clear");

    // Step moves the clock by the shadow nanoseconds in the chosen direction
    chk_step_shift: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (ctrl_q.step && !ctrl_q.load && !ctrl_q.clk_reset) |=>
        live_q == time_shift($past(live_q), $past(shadow_q.ns), !$past(ctrl_q.step_dir)))
        else $error("step adjustment wrong");

    // Snapshot copies the live clock unless the bus writes that cycle
    chk_snap_copy: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (ctrl_q.snap && !i_reg_wr) |=> shadow_q == $past(live_q))
        else $error("snapshot did not copy live time");

    // Load replaces the live clock
    chk_load_copy: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (ctrl_q.load && !ctrl_q.clk_reset) |=> live_q == $past(shadow_q))
        else $error("load did not copy shadow time");

    // Disabled clock holds still
    chk_hold_stopped: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (!ctrl_q.enable && !ctrl_q.load && !ctrl_q.step && !ctrl_q.clk_reset) |=>
        $stable(live_q))
        else $error("clock moved while disabled");

    // Clock reset zeroes the time and clears itself
    chk_clock_reset: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (ctrl_q.clk_reset && !wr_ctrl) |=> (live_q == '0) && !ctrl_q.clk_reset)
        else $error("clock reset failed");

    // Plain tick adds 40 ns, ticks every fourth cycle
    chk_tick_advance: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (tick && ctrl_q.enable && !ctrl_q.cont_adj && !ctrl_q.load && !ctrl_q.step
         && !ctrl_q.clk_reset && !wr_ctrl) ##1 (!ctrl_q.load && !ctrl_q.step
         && !ctrl_q.clk_reset && !wr_ctrl)[*3] |->
        !tick && $stable(live_q) ##0 (live_q == time_shift($past(live_q, 3), NS_PER_TICK, 1'b0)))
        else $error("plain tick advance wrong");

    // Rate fraction accumulates by the signed rate
    chk_rate_frac: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (tick && ctrl_q.enable && ctrl_q.cont_adj && !ctrl_q.load && !ctrl_q.step
         && !ctrl_q.clk_reset) |=>
        frac_q == ($past(rate_q.rate_sign_select)
            ? FRAC_W'($past(frac_q) + $past(rate_q.fractional_rate_value))
            : FRAC_W'($past(frac_q) - $past(rate_q.fractional_rate_value))))
        else $error("rate fraction wrong");

    // Follow output is off the cycle after the disable bit is set
    chk_follow_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        ctrl_q.freq_dis |=> !o_timer_follow)
        else $error("timers follow while disabled");

    // Reserved control bits read back zero
    chk_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_reg_rd && i_reg_addr == OFS_CTRL) |=> o_reg_rvalid && o_reg_rdata[14:7] == 8'h00)
        else $error("reserved control bits not zero");

    // Follow output is on for a running, adjusted clock when allowed
    chk_follow_on: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (ctrl_q.enable && ctrl_q.cont_adj && !ctrl_q.freq_dis) |=> o_timer_follow)
        else $error("timers not following adjustment");

    // Snapshot command lasts one cycle unless rewritten
    chk_snap_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (ctrl_q.snap && !wr_ctrl) |=> !ctrl_q.snap)
        else $error("snapshot command did not clear");

    // Load command lasts one cycle unless rewritten
    chk_load_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (ctrl_q.load && !wr_ctrl) |=> !ctrl_q.load)
        else $error("load command did not clear");

    // Phase word shows the stored slot code with upper bits zero
    chk_phase_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        (i_reg_rd && i_reg_addr == OFS_PHASE) |=> o_reg_rdata == {13'h0, $past(shadow_q.phase)})
        else $error("phase read back wrong");

    // Sign output follows the stored rate sign one cycle late
    chk_sign_copy: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        1'b1 |=> o_timer_sign == $past(rate_q.rate_sign_select))
        else $error("rate sign output wrong");

endmodule : rtcc_core

// ---- hw/rtcc_pkg.sv ----
// Package for the precision-time clock control block: offsets, fields,
// reset values, timing counts and the carrier structs.
// Assumes a 100 MHz system clock and 16-bit registers at byte offsets.
package rtcc_pkg;

    // Register byte offsets
    localparam logic [15:0] OFS_CTRL       = 16'h0500;
    localparam logic [15:0] OFS_PHASE      = 16'h0502;
    localparam logic [15:0] OFS_NS_UPPER   = 16'h0504;
    localparam logic [15:0] OFS_NS_LOWER   = 16'h0506;
    localparam logic [15:0] OFS_SEC_UPPER  = 16'h0508;
    localparam logic [15:0] OFS_SEC_LOWER  = 16'h050A;
    localparam logic [15:0] OFS_RATE_UPPER = 16'h050C;
    localparam logic [15:0] OFS_RATE_LOWER = 16'h050E;

    // Control and rate register field positions, and field widths
    localparam int BIT_FREQ_DIS  = 15;
    localparam int BIT_STEP      = 6;
    localparam int BIT_STEP_DIR  = 5;
    localparam int BIT_SNAP      = 4;
    localparam int BIT_LOAD      = 3;
    localparam int BIT_CONT_ADJ  = 2;
    localparam int BIT_ENABLE    = 1;
    localparam int BIT_CLK_RESET = 0;
    localparam int BIT_RATE_SIGN = 15;
    localparam int RATE_HI_W     = 14;
    localparam int PHASE_W       = 3;
    localparam int FRAC_W        = 30;

    // Reset values
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Timing: the time base ticks at 25 MHz, derived from the 100 MHz clock
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_PERIOD_NS = 40;
    localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [1:0]  TICK_LAST  = 2'(TICK_CYCLES - 1);
    localparam logic [31:0] NS_PER_TICK = 32'(TICK_PERIOD_NS);
    localparam logic [32:0] NS_PER_SEC  = 33'h03B9ACA00;

    // Live or shadow time value
    typedef struct packed {
        logic [PHASE_W-1:0] phase;
        logic [31:0]        sec;
        logic [31:0]        ns;
    } rtcc_time_s;

    // Stored control bits and self-clearing commands
    typedef struct packed {
        logic freq_dis;
        logic step;
        logic step_dir;
        logic snap;
        logic load;
        logic cont_adj;
        logic enable;
        logic clk_reset;
    } rtcc_ctrl_s;

    // Continuous rate setting
    typedef struct packed {
        logic              rate_sign_select;
        logic [FRAC_W-1:0] fractional_rate_value;
    } rtcc_rate_s;

endpackage : rtcc_pkg

// ---- testbench/rtcc_core_tb.sv ----
// Self-checking bench for the clock control and time value block.
// Assumes the block's strobe register port and its 4-cycle tick.
`timescale 1ns/1ps
module rtcc_core_tb;
    import rtcc_pkg::*;
    logic                i_clk;
    logic                i_reset_n;
    logic                i_reg_wr;
    logic                i_reg_rd;
    logic [15:0]         i_reg_addr;
    logic [15:0]         i_reg_wdata;
    logic [15:0]         o_reg_rdata;
    logic                o_reg_rvalid;
    rtcc_time_s          o_rtc_time;
    logic                o_rtc_running;
    logic                o_timer_follow;
    logic                o_timer_sign;
    int                  miscompares;
    int                  samples_checked;
    int                  cycles;
    logic [15:0]         rd_q;
    logic [31:0]         ns0;

    rtcc_core dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_rtc_time(o_rtc_time),
        .o_rtc_running(o_rtc_running), .o_timer_follow(o_timer_follow),
        .o_timer_sign(o_timer_sign));

    // Clock, 10 ns period
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            close_out();
        end
    end

    task automatic close_out();
        $display("Counts: %0d miscompares, %0d samples checked", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [66:0] got, input logic [66:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Wait n edges, then step past them so outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr    <= 1'b0;
    endtask : wr

    // Read answer stands just after the taking edge, registered on it
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd   <= 1'b0;
        #1;
        chk(67'(o_reg_rvalid), 67'h1);
        chk(67'(o_reg_rdata), 67'(exp));
    endtask : rd

    task automatic s_reset_vals();
        for (int a = 16'h0500; a <= 16'h0510; a += 2) begin
            rd(16'(a), 16'h0000);
        end
        chk(67'(o_rtc_running), 67'h0);
    endtask : s_reset_vals

    task automatic s_reserved();
        wr(OFS_CTRL, 16'h7F80);
        rd(OFS_CTRL, 16'h0000);
        wr(OFS_PHASE, 16'hFFFC);
        rd(OFS_PHASE, 16'h0004);
    endtask : s_reserved

    // Load with the clock stopped so the live value must equal the shadow
    task automatic s_load();
        wr(OFS_PHASE, 16'h0002);
        wr(OFS_NS_UPPER, 16'h0000);
        wr(OFS_NS_LOWER, 16'h03E8);
        wr(OFS_SEC_UPPER, 16'h0001);
        wr(OFS_SEC_LOWER, 16'h0002);
        wr(OFS_CTRL, 16'h0008);
        cyc(2);
        chk(o_rtc_time, {3'h2, 32'h0001_0002, 32'h0000_03E8});
        rd(OFS_CTRL, 16'h0000);
    endtask : s_load

    task automatic s_step();
        wr(OFS_NS_LOWER, 16'h012C);
        wr(OFS_CTRL, 16'h0060);
        cyc(2);
        chk(67'(o_rtc_time.ns), 67'h514);
        rd(OFS_CTRL, 16'h0020);
        wr(OFS_CTRL, 16'h0040);
        cyc(2);
        chk(67'(o_rtc_time.ns), 67'h3E8);
    endtask : s_step

    // Shadow ns lower still holds the step value, so a copy must show
    task automatic s_snapshot();
        wr(OFS_PHASE, 16'h0000);
        wr(OFS_SEC_UPPER, 16'hFFFF);
        wr(OFS_CTRL, 16'h0010);
        cyc(2);
        rd(OFS_PHASE, 16'h0002);
        rd(OFS_NS_LOWER, 16'h03E8);
        rd(OFS_SEC_UPPER, 16'h0001);
        rd(OFS_SEC_LOWER, 16'h0002);
        rd(OFS_CTRL, 16'h0000);
    endtask : s_snapshot

    task automatic s_clear();
        wr(OFS_CTRL, 16'h0001);
        cyc(2);
        chk(o_rtc_time, 67'h0);
        rd(OFS_CTRL, 16'h0000);
    endtask : s_clear

    // Start 40 ns short of a second; the first tick must carry exactly
    task automatic s_carry();
        wr(OFS_NS_UPPER, 16'h3B9A);
        wr(OFS_NS_LOWER, 16'hC9D8);
        wr(OFS_SEC_UPPER, 16'h0000);
        wr(OFS_SEC_LOWER, 16'h0005);
        wr(OFS_PHASE, 16'h0000);
        wr(OFS_CTRL, 16'h0008);
        wr(OFS_CTRL, 16'h0002);
        cyc(1);
        chk(67'(o_rtc_running), 67'h1);
        for (int i = 0; i < 8 && o_rtc_time.sec == 32'h5; i++) begin
            cyc(1);
        end
        chk(o_rtc_time, {3'h0, 32'h6, 32'h0});
        ns0 = o_rtc_time.ns;
        cyc(40);
        chk(67'(o_rtc_time.ns - ns0), 67'd400);
        wr(OFS_CTRL, 16'h0000);
        cyc(1);
        ns0 = o_rtc_time.ns;
        cyc(12);
        chk(67'(o_rtc_time.ns), 67'(ns0));
    endtask : s_carry

    // Half a nanosecond a tick: ten ticks move the count by exactly five
    task automatic s_rate();
        wr(OFS_CTRL, 16'h0001);
        wr(OFS_RATE_UPPER, 16'hA000);
        wr(OFS_RATE_LOWER, 16'h0000);
        wr(OFS_CTRL, 16'h0006);
        cyc(2);
        chk(67'({o_timer_follow, o_timer_sign}), 67'h3);
        ns0 = o_rtc_time.ns;
        cyc(40);
        chk(67'(o_rtc_time.ns - ns0), 67'd405);
        wr(OFS_RATE_UPPER, 16'h2000);
        cyc(2);
        chk(67'(o_timer_sign), 67'h0);
        ns0 = o_rtc_time.ns;
        cyc(40);
        chk(67'(o_rtc_time.ns - ns0), 67'd395);
        wr(OFS_CTRL, 16'h8006);
        cyc(2);
        chk(67'(o_timer_follow), 67'h0);
        rd(OFS_CTRL, 16'h8006);
        wr(OFS_CTRL, 16'h0002);
        cyc(2);
        chk(67'(o_timer_follow), 67'h0);
    endtask : s_rate

    // Main sequence
    initial begin
        miscompares     = 0;
        samples_checked = 0;
        cycles          = 0;
        i_reset_n       = 1'b0;
        i_reg_wr        = 1'b0;
        i_reg_rd        = 1'b0;
        i_reg_addr      = 16'h0000;
        i_reg_wdata     = 16'h0000;
        repeat (8) @(posedge i_clk);
        i_reset_n <= 1'b1;
        s_reset_vals();
        s_reserved();
        s_load();
        s_step();
        s_snapshot();
        s_clear();
        s_carry();
        s_rate();
        close_out();
    end
endmodule : rtcc_core_tb
